// File: bench/afw_filter_props.sv
// timing checks on the filter decision and wake outputs
module afw_filter_props (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       rx_valid,
   input wire logic       rx_eof,
   input wire logic       wakeup_detect_enable,
   input wire logic       wake_frame_rcvd_clr,
   input wire logic       frame_accept,
   input wire logic       frame_reject,
   input wire logic       wake_event,
   input wire logic       wake_frame_rcvd,
   input wire logic [3:0] wake_filter_hit
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   a_one_decision: assert property (!(frame_accept && frame_reject))
      else $error("accept and reject together");
   a_accept_single: assert property (frame_accept |=> !frame_accept)
      else $error("accept longer than one cycle");
   a_decide_after_byte: assert property ((frame_accept || frame_reject) |-> $past(rx_valid, 2))
      else $error("decision not two cycles after a byte");
   a_wake_no_accept: assert property (wakeup_detect_enable && $past(wakeup_detect_enable)
      && $past(wakeup_detect_enable, 2) |-> !frame_accept) else $error("accept in wake mode");
   a_wake_after_eof: assert property (wake_event |-> $past(rx_valid && rx_eof, 2))
      else $error("wake not two cycles after last byte");
   a_wake_sets_flag: assert property (wake_event |-> wake_frame_rcvd)
      else $error("wake without received flag");
   a_flag_by_wake: assert property ($rose(wake_frame_rcvd) |-> wake_event)
      else $error("flag rose without wake");
   a_flag_sticky: assert property (wake_frame_rcvd && !wake_frame_rcvd_clr |=> wake_frame_rcvd)
      else $error("flag dropped without clear");
   a_flag_clear: assert property (wake_frame_rcvd_clr |=> !wake_frame_rcvd || wake_event)
      else $error("flag not cleared");
   a_wake_has_hit: assert property (wake_event |-> wake_filter_hit != 4'h0)
      else $error("wake with no filter hit");
endmodule

bind afw_filter afw_filter_props u_props (.ref_clk, .rst, .rx_valid, .rx_eof,
   .wakeup_detect_enable, .wake_frame_rcvd_clr, .frame_accept, .frame_reject, .wake_event,
   .wake_frame_rcvd, .wake_filter_hit);

// File: bench/afw_rx_src.sv
// behavioural receive datapath handing whole frames to the filter
module afw_rx_src (
   input  wire logic ref_clk,
   output logic      rx_valid,
   output logic      rx_sof,
   output logic      rx_eof,
   output logic [7:0] rx_data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      rx_valid = 1'b0;
      rx_sof   = 1'b0;
      rx_eof   = 1'b0;
      rx_data  = 8'h00;
   end
   task automatic send(input logic [7:0] f [12]);
      for (int i = 0; i < 12; i++) begin
         @(posedge ref_clk);
         #1;
         rx_valid = 1'b1;
         rx_sof   = (i == 0);
         rx_eof   = (i == 11);
         rx_data  = f[i];
      end
      @(posedge ref_clk);
      #1;
      rx_valid = 1'b0;
      rx_sof   = 1'b0;
      rx_eof   = 1'b0;
      // stale byte inverted so idle data never looks valid
      rx_data  = ~rx_data;
   endtask
endmodule

// File: bench/test_afw_filter.sv
// self-checking bench for the receive address filter and wake detector
module test_afw_filter;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk, rst, rx_valid, rx_sof, rx_eof, bd, wen, wue, clr, wr, rd, pr;
   logic        acc, rej, pass, wev, wfr;
   logic [7:0]  rx_data;
   logic [4:0]  mode;
   logic [3:0]  hit;
   logic [31:0] hth, htl, wdata, rdata;
   logic [7:0]  fr [12];
   logic [47:0] das [4] = '{48'h554433221102, 48'h564433221102, 48'h554433221103, '1};
   int          fails, checked, n_acc, n_rej, n_wev, cyc;

   afw_rx_src src (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
      .rx_data(rx_data));
   afw_filter uut (.ref_clk(ref_clk), .rst(rst), .rx_valid(rx_valid), .rx_sof(rx_sof),
      .rx_eof(rx_eof), .rx_data(rx_data), .multicast_pass_all(mode[4]),
      .promiscuous_en(mode[3]), .inverse_filter_en(mode[2]), .hash_filter_en(mode[1]),
      .hash_perfect_en(mode[0]), .broadcast_disable(bd), .station_address_high(16'h5544),
      .station_address_low(32'h33221102), .hash_table_high(hth), .hash_table_low(htl),
      .wakeup_detect_enable(wen), .wake_unicast_en(wue), .wake_frame_rcvd_clr(clr),
      .wpf_wr_en(wr), .wpf_wr_data(wdata), .wpf_rd_en(rd), .wpf_ptr_reset(pr),
      .wpf_rd_data(rdata), .frame_accept(acc), .frame_reject(rej), .frame_pass(pass),
      .wake_event(wev), .wake_frame_rcvd(wfr), .wake_filter_hit(hit));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (acc === 1'b1) n_acc++;
      if (rej === 1'b1) n_rej++;
      if (wev === 1'b1) n_wev++;
      cyc++;
      // a hung wait ends the run instead of stalling it
      if (cyc == 5000) begin
         fails++;
         test_done();
      end
   end

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic test_done();
      $display("mismatches %0d of %0d checks", fails, checked);
      if (fails == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic mk(input logic [47:0] da);
      for (int i = 0; i < 12; i++) fr[i] = (i < 6) ? da[8*i +: 8] : 8'h10 + 8'(i);
   endtask
   task automatic run(input logic ea, input logic ew);
      n_acc = 0;
      n_rej = 0;
      n_wev = 0;
      src.send(fr);
      repeat (4) @(posedge ref_clk);
      #1;
      chk("frame_accept", n_acc, 32'(ea));
      chk("frame_reject", n_rej, 32'(!ea));
      chk("frame_pass", 32'(pass), 32'(ea));
      chk("wake_event", n_wev, 32'(ew));
   endtask
   task automatic reg_op(input int op, input logic [31:0] d);
      @(posedge ref_clk);
      #1;
      wr = (op == 0);
      rd = (op == 1);
      pr = (op == 2);
      wdata = d;
      @(posedge ref_clk);
      #1;
      {wr, rd, pr} = 3'h0;
   endtask
   function automatic logic [5:0] c32();
      logic [31:0] c;
      c = afw_pkg::CRC32_INIT;
      for (int i = 0; i < 48; i++)
         c = (c >> 1) ^ ((c[0] ^ fr[i/8][i%8]) ? afw_pkg::CRC32_POLY : 32'h0);
      return c[31:26];
   endfunction
   function automatic logic [15:0] c16(input int off, input logic [30:0] m);
      logic [15:0] c;
      c = afw_pkg::CRC16_INIT;
      for (int j = 0; j < 31; j++) if (m[j] && off + j < 12) for (int b = 0; b < 8; b++)
         c = (c >> 1) ^ ((c[0] ^ fr[off+j][b]) ? afw_pkg::CRC16_POLY : 16'h0);
      return c;
   endfunction

   task automatic sc_modes();
      logic [4:0] md [7] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13};
      logic [3:0] ex [7] = '{4'h1, 4'h1, 4'h0, 4'he, 4'hf, 4'hd, 4'hc};
      // hash table empty, so any hashed destination is dropped
      for (int m = 0; m < 7; m++) begin
         mode = md[m];
         for (int d = 0; d < 4; d++) begin
            mk(das[d]);
            run(ex[m][d], 1'b0);
         end
      end
   endtask
   task automatic sc_hash();
      logic [63:0] t;
      mode = 5'h03;
      mk(das[1]);
      t = 64'h1 << c32();
      {hth, htl} = t;
      run(1'b1, 1'b0);
      {hth, htl} = ~t;
      run(1'b0, 1'b0);
      {hth, htl} = 64'h0;
      mode = 5'h00;
   endtask
   task automatic sc_wake();
      logic [31:0] w [8];
      mk(das[0]);
      w[0] = 32'h3f;
      w[1] = 32'h3f;
      w[6] = {~c16(0, 31'h3f), c16(0, 31'h3f)};
      mk(das[3]);
      w[2] = 32'h1;
      w[3] = 32'h0;
      w[4] = 32'h00090101;
      w[5] = 32'h00060000;
      w[7] = {16'h0, c16(6, 31'h1)};
      reg_op(2, 32'h0);
      reg_op(1, 32'h0);
      chk("wpf_rd_data", rdata, afw_pkg::WPF_RESET);
      reg_op(2, 32'h0);
      for (int i = 0; i < 8; i++) reg_op(0, w[i]);
      for (int i = 0; i < 8; i++) begin
         reg_op(1, 32'h0);
         chk("wpf_rd_data", rdata, w[i]);
      end
      bd = 1'b1;
      wen = 1'b1;
      mk(das[0]);
      run(1'b0, 1'b1);
      chk("wake_filter_hit", 32'(hit), 32'h1);
      chk("wake_frame_rcvd", 32'(wfr), 32'h1);
      @(posedge ref_clk);
      #1 clr = 1'b1;
      @(posedge ref_clk);
      #1 clr = 1'b0;
      chk("wake_frame_rcvd", 32'(wfr), 32'h0);
      mk(das[3]);
      run(1'b0, 1'b1);
      chk("wake_filter_hit", 32'(hit), 32'h4);
      mk(das[1]);
      run(1'b0, 1'b0);
      // foreign unicast wakes only through the global unicast enable
      wue = 1'b1;
      run(1'b0, 1'b1);
      chk("wake_filter_hit", 32'(hit), 32'h4);
      wue = 1'b0;
      wen = 1'b0;
      bd = 1'b0;
      mk(das[0]);
      run(1'b1, 1'b0);
   endtask

   initial begin
      {rst, bd, wen, clr, wr, rd, pr} = 7'h40;
      {wue, mode, hth, htl, wdata} = '0;
      {fails, checked, cyc} = '0;
      repeat (16) @(posedge ref_clk);
      #1 rst = 1'b0;
      sc_modes();
      sc_hash();
      sc_wake();
      test_done();
   end
endmodule

// File: logic/afw_crc.sv
// byte-wide lsb-first crc register with load and step
module afw_crc #(
   parameter int                WIDTH = 32,
   parameter logic [WIDTH-1:0]  POLY  = '0,
   parameter logic [WIDTH-1:0]  INIT  = '1
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             start,
   input  wire logic             en,
   input  wire logic [7:0]       data,
   output logic      [WIDTH-1:0] crc
);

   logic [WIDTH-1:0] crc_q;
   logic [WIDTH-1:0] crc_d;

   function automatic logic [WIDTH-1:0] step(input logic [WIDTH-1:0] c_in,
                                             input logic [7:0]       d);
      logic [WIDTH-1:0] c;
      logic             fb;
      c = c_in;
      for (int b = 0; b < 8; b++) begin
         fb = c[0] ^ d[b];
         c  = c >> 1;
         if (fb) begin
            c = c ^ POLY;
         end
      end
      return c;
   endfunction

   always_comb begin
      logic [WIDTH-1:0] base;
      base  = start ? INIT : crc_q;
      crc_d = en ? step(base, data) : base;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         crc_q <= INIT;
      end else begin
         crc_q <= crc_d;
      end
   end

   assign crc = crc_q;

endmodule

// File: logic/afw_filter.sv
// receive destination address filter with four-pattern wakeup frame detection
// Functional notes
// R1: first received destination bit marks multicast versus physical address.
// R2: a frame failing the active filter is not forwarded to host buffers; broadcast_disable blocks frame_accept but not frame_pass.
// R3: all mode bits clear: perfect station address match for every frame.
// R4: hash-perfect only: physical perfect-matched, multicast checked in hash table.
// R5: both hash bits set: hash table filtering for every destination.
// R6: inverse mode accepts non-matching destinations, rejects the station address.
// R7: promiscuous accepts every frame, broadcast included, ignoring other bits.
// R8: pass-all-multicast accepts multicast; physical frames perfect or hash filtered.
// R9: perfect match compares destination with the high and low station address.
// R10: hash uses upper six crc bits indexing a 64-bit table; set passes.
// R11: top index bit picks high or low word, five bits pick the bit.
// R12: in wake mode normal reception stops, only pattern checking runs.
// R13: a wakeup frame pulses the wake event and sets the received flag.
// R14: clearing wake enable returns the block to normal reception.
// R15: four pattern filters, each with mask, offset, command and crc-16.
// R16: wake only when address filtering passes and the computed crc matches; the code also wakes on broadcast and, with wake_unicast_en, on any unicast.
// R17: 31-bit byte mask; bit j includes byte offset plus j in crc.
// R18: eight sequential writes load masks, command, offset, then two crc words.
// R19: crc words hold two values, lower filter in the lower half.
// R20: software programs patterns before enabling wake detection.
// R21: broadcast wakeup frames wake even with broadcast disabled.
// R22: wake detection runs in every power state while enabled.
// R23: command bit 0 enables a filter, bit 3 selects multicast or unicast.
// R24: pattern offset is an 8-bit field; zero is first destination byte.
// R25: crc-16 over masked bytes equal to the expected value means wakeup.
// R26: broadcast or global unicast wakes directly, else regular pass plus type.
// R27: hash index comes from ethernet crc-32 over six destination bytes.
// R28: decision taken after six destination bytes, applied to the whole frame.
module afw_filter (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        rx_valid,
   input  wire logic        rx_sof,
   input  wire logic        rx_eof,
   input  wire logic [7:0]  rx_data,
   input  wire logic        multicast_pass_all,
   input  wire logic        promiscuous_en,
   input  wire logic        inverse_filter_en,
   input  wire logic        hash_filter_en,
   input  wire logic        hash_perfect_en,
   input  wire logic        broadcast_disable,
   input  wire logic [15:0] station_address_high,
   input  wire logic [31:0] station_address_low,
   input  wire logic [31:0] hash_table_high,
   input  wire logic [31:0] hash_table_low,
   input  wire logic        wakeup_detect_enable,
   input  wire logic        wake_unicast_en,
   input  wire logic        wake_frame_rcvd_clr,
   input  wire logic        wpf_wr_en,
   input  wire logic [31:0] wpf_wr_data,
   input  wire logic        wpf_rd_en,
   input  wire logic        wpf_ptr_reset,
   output logic      [31:0] wpf_rd_data,
   output logic             frame_accept,
   output logic             frame_reject,
   output logic             frame_pass,
   output logic             wake_event,
   output logic             wake_frame_rcvd,
   output logic      [3:0]  wake_filter_hit
);

   localparam int NF = afw_pkg::WAKE_FILTERS;
   localparam int W  = afw_pkg::WPF_W;
   localparam int WPF_WORDS_BITS = afw_pkg::WPF_WORDS * afw_pkg::WPF_W;

   // frame tracking state
   afw_pkg::afw_state_e             state_q;
   afw_pkg::afw_state_e             state_d;
   logic [afw_pkg::IDX_W-1:0]       idx_q;
   logic [afw_pkg::IDX_W-1:0]       idx_d;
   logic                            da_match_q;
   logic                            da_match_d;
   logic                            broadcast_disable_q;
   logic                            broadcast_disable_d;
   logic                            mcast_q;
   logic                            mcast_d;
   logic                            decide_q;
   logic                            decide_d;
   logic                            eof_q;
   logic                            eof_d;
   logic                            decided_q;
   logic                            decided_d;
   logic                            pass_q;
   logic                            pass_d;

   // decision outputs
   logic                            accept_q;
   logic                            accept_d;
   logic                            reject_q;
   logic                            reject_d;
   logic                            wake_q;
   logic                            wake_d;
   logic                            rcvd_q;
   logic                            rcvd_d;
   logic [NF-1:0]                   hit_q;
   logic [NF-1:0]                   hit_d;

   // combinational helpers
   logic                            byte_ok;
   logic                            sof_byte;
   logic [afw_pkg::IDX_W-1:0]       cur_idx;
   logic                            in_da;
   logic [afw_pkg::DA_BITS-1:0]     station_addr;
   logic [7:0]                      sa_byte;
   logic [afw_pkg::CRC32_W-1:0]     crc32;
   logic [afw_pkg::HASH_IDX_W-1:0]  hash_idx;
   logic                            hash_hit;
   logic                            accept_now;
   logic                            pass_now;
   logic [NF-1:0]                   filt_hit;
   logic [WPF_WORDS_BITS-1:0]       words;

   afw_pattern_regs u_regs (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .wr_en     (wpf_wr_en),
      .wr_data   (wpf_wr_data),
      .rd_en     (wpf_rd_en),
      .ptr_reset (wpf_ptr_reset),
      .rd_data   (wpf_rd_data),
      .words     (words)
   );

   assign byte_ok  = rx_valid && (rx_sof || (state_q != afw_pkg::ST_IDLE));
   assign sof_byte = rx_valid && rx_sof;
   assign cur_idx  = rx_sof ? '0 : idx_q;
   assign in_da    = (cur_idx <= afw_pkg::IDX_LAST_DA);

   assign station_addr = {station_address_high, station_address_low};  // see R9
   assign sa_byte      = station_addr[cur_idx[afw_pkg::DA_CNT_W-1:0]*8 +: 8];

   // destination crc-32 for the hash index, six bytes only
   afw_crc #(
      .WIDTH (afw_pkg::CRC32_W),
      .POLY  (afw_pkg::CRC32_POLY),
      .INIT  (afw_pkg::CRC32_INIT)
   ) u_hash_crc (
      .ref_clk (ref_clk),
      .rst     (rst),
      .start   (sof_byte),
      .en      (byte_ok && in_da),  // see R27
      .data    (rx_data),
      .crc     (crc32)
   );

   assign hash_idx = crc32[afw_pkg::HASH_TOP -: afw_pkg::HASH_IDX_W];  // see R10
   // top index bit selects the word, the rest the bit within it
   assign hash_hit = hash_idx[afw_pkg::HASH_SEL_BIT] ?
                     hash_table_high[hash_idx[4:0]] :
                     hash_table_low[hash_idx[4:0]];  // see R11

   // address decision, valid while decide_q
   always_comb begin
      accept_now = da_match_q;  // see R3
      if (promiscuous_en) begin
         accept_now = 1'b1;  // see R7
      end else if (mcast_q && multicast_pass_all) begin
         accept_now = 1'b1;  // see R8
      end else if (inverse_filter_en) begin
         accept_now = !da_match_q;  // see R6
      end else if (hash_filter_en && hash_perfect_en) begin
         accept_now = hash_hit;  // see R5
      end else if (hash_perfect_en && mcast_q) begin
         accept_now = hash_hit;  // see R4
      end
   end

   assign pass_now = decide_q ? accept_now : pass_q;

   // per-filter masked crc-16 and wake qualification
   genvar f;
   generate
      for (f = 0; f < NF; f++) begin : g_wake
         logic [afw_pkg::MASK_W-1:0]      mask;
         logic [afw_pkg::CMD_FIELD_W-1:0] cmd;
         logic [afw_pkg::OFFSET_W-1:0]    offs;
         logic [afw_pkg::CRC_FIELD_W-1:0] expect_crc;
         logic [9:0]                      rel;
         logic                            in_win;
         logic                            upd;
         logic [afw_pkg::CRC16_W-1:0]     crc16;
         logic                            crc_ok;

         assign mask = words[(afw_pkg::WPF_MASK0_IDX + f)*W +: afw_pkg::MASK_W];  // see R15
         assign cmd  = words[afw_pkg::WPF_CMD_IDX*W + f*afw_pkg::CMD_FIELD_W +:
                             afw_pkg::CMD_FIELD_W];
         assign offs = words[afw_pkg::WPF_OFFSET_IDX*W + f*afw_pkg::OFFSET_W +:
                             afw_pkg::OFFSET_W];  // see R24
         // lower-numbered filter sits in the lower half of each crc word
         assign expect_crc = words[(afw_pkg::WPF_CRC01_IDX + f/2)*W +
                                   (f%2)*afw_pkg::CRC_FIELD_W +: afw_pkg::CRC_FIELD_W];  // see R19

         assign rel    = {1'b0, cur_idx} - {2'b00, offs};
         assign in_win = !rel[9] && (rel < afw_pkg::WIN_LEN);
         assign upd    = byte_ok && in_win && mask[rel[4:0]];  // see R17

         afw_crc #(
            .WIDTH (afw_pkg::CRC16_W),
            .POLY  (afw_pkg::CRC16_POLY),
            .INIT  (afw_pkg::CRC16_INIT)
         ) u_wcrc (
            .ref_clk (ref_clk),
            .rst     (rst),
            .start   (sof_byte),
            .en      (upd),
            .data    (rx_data),
            .crc     (crc16)
         );

         assign crc_ok = (crc16 == expect_crc);  // see R25
         // broadcast wakes even when broadcast is disabled for normal traffic
         assign filt_hit[f] = cmd[afw_pkg::CMD_ENABLE_BIT] && crc_ok &&
                              (broadcast_disable_q ||
                               (!mcast_q && wake_unicast_en) ||
                               (pass_now && !broadcast_disable_q &&
                                (cmd[afw_pkg::CMD_ADDR_TYPE_BIT] == mcast_q)));  // see R21 R23 R26
      end
   endgenerate

   // frame tracking
   always_comb begin
      state_d    = state_q;
      idx_d      = idx_q;
      da_match_d = da_match_q;
      broadcast_disable_d    = broadcast_disable_q;
      mcast_d    = mcast_q;
      decided_d  = decided_q;
      pass_d     = pass_q;
      decide_d   = 1'b0;
      eof_d      = 1'b0;
      if (decide_q) begin
         pass_d    = accept_now;
         decided_d = 1'b1;
      end
      if (byte_ok) begin
         idx_d = (cur_idx == afw_pkg::IDX_MAX) ? cur_idx : cur_idx + 9'h001;
         if (rx_sof) begin
            decided_d = 1'b0;
            pass_d    = 1'b0;
            mcast_d   = rx_data[afw_pkg::MCAST_BIT];  // see R1
         end
         if (in_da) begin
            da_match_d = (rx_sof || da_match_q) && (rx_data == sa_byte);
            broadcast_disable_d    = (rx_sof || broadcast_disable_q) && (rx_data == afw_pkg::BROADCAST_DISABLE_BYTE);
         end
         decide_d = (cur_idx == afw_pkg::IDX_LAST_DA);  // see R28
         eof_d    = rx_eof;
         if (rx_eof) begin
            state_d = afw_pkg::ST_IDLE;
         end else if (decide_d) begin
            state_d = afw_pkg::ST_BODY;
         end else if (rx_sof) begin
            state_d = afw_pkg::ST_ADDR;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q    <= afw_pkg::ST_IDLE;
         idx_q      <= '0;
         da_match_q <= 1'b0;
         broadcast_disable_q    <= 1'b0;
         mcast_q    <= 1'b0;
         decide_q   <= 1'b0;
         eof_q      <= 1'b0;
         decided_q  <= 1'b0;
         pass_q     <= 1'b0;
      end else begin
         state_q    <= state_d;
         idx_q      <= idx_d;
         da_match_q <= da_match_d;
         broadcast_disable_q    <= broadcast_disable_d;
         mcast_q    <= mcast_d;
         decide_q   <= decide_d;
         eof_q      <= eof_d;
         decided_q  <= decided_d;
         pass_q     <= pass_d;
      end
   end

   // decisions and wake status; no power state input gates wake detection
   always_comb begin
      logic frame_ok;
      frame_ok = accept_now && !(broadcast_disable_q && broadcast_disable && !promiscuous_en);
      accept_d = 1'b0;
      reject_d = 1'b0;
      wake_d   = 1'b0;
      hit_d    = hit_q;
      if (decide_q) begin
         // wake mode halts normal reception; dropping the enable resumes it
         accept_d = frame_ok && !wakeup_detect_enable;  // see R2 R12 R14
         reject_d = !accept_d;
      end else if (eof_q && !decided_q) begin
         reject_d = 1'b1;  // runt shorter than a destination address
      end
      if (eof_q && wakeup_detect_enable && (decided_q || decide_q)) begin  // see R16 R22
         wake_d = |filt_hit;  // see R13
         if (|filt_hit) begin
            hit_d = filt_hit;
         end
      end
      // a new wake wins over a clear in the same cycle
      rcvd_d = wake_d || (rcvd_q && !wake_frame_rcvd_clr);  // see R13
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         accept_q <= 1'b0;
         reject_q <= 1'b0;
         wake_q   <= 1'b0;
         rcvd_q   <= 1'b0;
         hit_q    <= '0;
      end else begin
         accept_q <= accept_d;
         reject_q <= reject_d;
         wake_q   <= wake_d;
         rcvd_q   <= rcvd_d;
         hit_q    <= hit_d;
      end
   end

   assign frame_accept    = accept_q;
   assign frame_reject    = reject_q;
   assign frame_pass      = pass_q && !wakeup_detect_enable;
   assign wake_event      = wake_q;
   assign wake_frame_rcvd = rcvd_q;
   assign wake_filter_hit = hit_q;

endmodule

// File: logic/afw_pattern_regs.sv
// eight-word wake pattern filter store behind one sequential register
module afw_pattern_regs (
   input  wire logic                                     ref_clk,
   input  wire logic                                     rst,
   input  wire logic                                     wr_en,
   input  wire logic [afw_pkg::WPF_W-1:0]                wr_data,
   input  wire logic                                     rd_en,
   input  wire logic                                     ptr_reset,
   output logic      [afw_pkg::WPF_W-1:0]                rd_data,
   output logic      [afw_pkg::WPF_WORDS*afw_pkg::WPF_W-1:0] words
);

   logic [afw_pkg::WPF_W-1:0]     mem_q [afw_pkg::WPF_WORDS];
   logic [afw_pkg::WPF_W-1:0]     mem_d [afw_pkg::WPF_WORDS];
   logic [afw_pkg::WPF_PTR_W-1:0] ptr_q;
   logic [afw_pkg::WPF_PTR_W-1:0] ptr_d;
   logic [afw_pkg::WPF_W-1:0]     rd_q;
   logic [afw_pkg::WPF_W-1:0]     rd_d;

   // one pointer shared by reads and writes; it wraps after the eighth word
   always_comb begin
      mem_d = mem_q;
      ptr_d = ptr_q;
      rd_d  = rd_q;
      if (ptr_reset) begin
         ptr_d = '0;
      end else if (wr_en) begin
         mem_d[ptr_q] = wr_data;  // see R18
         ptr_d        = ptr_q + 3'h1;
      end else if (rd_en) begin
         rd_d  = mem_q[ptr_q];
         ptr_d = ptr_q + 3'h1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < afw_pkg::WPF_WORDS; i++) begin
            mem_q[i] <= afw_pkg::WPF_RESET;
         end
         ptr_q <= '0;
         rd_q  <= afw_pkg::WPF_RESET;
      end else begin
         mem_q <= mem_d;
         ptr_q <= ptr_d;
         rd_q  <= rd_d;
      end
   end

   assign rd_data = rd_q;

   genvar g;
   generate
      for (g = 0; g < afw_pkg::WPF_WORDS; g++) begin : g_words
         assign words[g*afw_pkg::WPF_W +: afw_pkg::WPF_W] = mem_q[g];
      end
   endgenerate

endmodule

// File: logic/afw_pkg.sv
// shared constants and types of the receive address filter and wake detector
package afw_pkg;

   // destination address
   localparam int           DA_BYTES        = 6;
   localparam int           DA_BITS         = 48;
   localparam int           DA_CNT_W        = 3;
   localparam int           MCAST_BIT       = 0;
   localparam logic [7:0]   BROADCAST_DISABLE_BYTE      = 8'hff;

   // frame byte counter, saturating
   localparam int           IDX_W           = 9;
   localparam logic [8:0]   IDX_MAX         = 9'h1ff;
   localparam logic [8:0]   IDX_LAST_DA     = 9'h005;

   // hash table
   localparam int           HASH_IDX_W      = 6;
   localparam int           HASH_SEL_BIT    = 5;
   localparam int           HASH_TOP        = 31;

   // crc engines, both shifted lsb first as bits arrive on the wire
   localparam int           CRC32_W         = 32;
   localparam logic [31:0]  CRC32_POLY      = 32'hedb88320;
   localparam logic [31:0]  CRC32_INIT      = 32'hffffffff;
   localparam int           CRC16_W         = 16;
   localparam logic [15:0]  CRC16_POLY      = 16'ha001;
   localparam logic [15:0]  CRC16_INIT      = 16'hffff;

   // wake pattern filter word layout
   localparam int           WPF_WORDS       = 8;
   localparam int           WPF_PTR_W       = 3;
   localparam int           WPF_W           = 32;
   localparam logic [31:0]  WPF_RESET       = 32'h00000000;
   localparam int           WPF_MASK0_IDX   = 0;
   localparam int           WPF_CMD_IDX     = 4;
   localparam int           WPF_OFFSET_IDX  = 5;
   localparam int           WPF_CRC01_IDX   = 6;
   localparam int           WPF_CRC23_IDX   = 7;
   localparam int           WAKE_FILTERS    = 4;
   localparam int           MASK_W          = 31;
   localparam int           CMD_FIELD_W     = 8;
   localparam int           CMD_ENABLE_BIT  = 0;
   localparam int           CMD_ADDR_TYPE_BIT = 3;
   localparam int           OFFSET_W        = 8;
   localparam int           CRC_FIELD_W     = 16;
   localparam logic [9:0]   WIN_LEN         = 10'h01f;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_BODY = 2'b10
   } afw_state_e;

endpackage
